// ==== shared/pss_pkg.sv ====
// Constants and types shared by the supply sequencer design
package pss_pkg;

  // Clock and system reset release delay
  localparam int CLK_HZ = 100000000;
  localparam int RESET_DELAY_MS = 60;
  localparam int RESET_DELAY_CYCLES = RESET_DELAY_MS * (CLK_HZ / 1000);
  localparam int RESET_CNT_W = 23;

  // Regulator output voltage codes, index into the selectable voltage list
  localparam logic [3:0] VSEL_1V8 = 4'h1;
  localparam logic [3:0] VSEL_3V0 = 4'hB;
  localparam logic [3:0] CORE_VSEL_RESET = VSEL_1V8;
  localparam logic [3:0] DIGI_VSEL_RESET = VSEL_3V0;
  localparam logic [3:0] ANA_VSEL_RESET = VSEL_3V0;

  // Charge current codes, one step is 50 mA
  localparam logic [4:0] ICHG_MIN_CODE = 5'h01;
  localparam logic [4:0] ICHG_MAX_CODE = 5'h13;
  localparam logic [4:0] ICHG_RESET = 5'h02;
  localparam logic [4:0] ICHG_PRECHARGE = 5'h01;
  localparam logic [4:0] ICHG_USB_LOW = 5'h02;
  localparam logic [4:0] ICHG_USB_HIGH = 5'h09;

  // Termination voltage: 0=4.1 V, 1=4.2 V, 2=4.3 V, 3=4.4 V
  localparam logic [1:0] TERM_RESET = 2'h1;
  // Restart offset: 0=100 mV, 1=150 mV, 2=200 mV, 3 reserved
  localparam logic [1:0] RESTART_RESET = 2'h1;
  localparam logic [1:0] RESTART_RESERVED = 2'h3;
  // End of charge: 0=0.1C, 1=0.15C, 2=0.2C, 3=0.25C
  localparam logic [1:0] EOC_RESET = 2'h0;

  // Synchronised input bit positions
  localparam int SYNC_W = 13;
  localparam int S_PWR_REQ = 0;
  localparam int S_HF_REQ = 1;
  localparam int S_HOLD = 2;
  localparam int S_OSC_EN = 3;
  localparam int S_RX_EN = 4;
  localparam int S_TX_EN = 5;
  localparam int S_CORE_OK = 6;
  localparam int S_DIGI_OK = 7;
  localparam int S_SRC_OK = 8;
  localparam int S_BELOW_PRE = 9;
  localparam int S_AT_TERM = 10;
  localparam int S_BELOW_EOC = 11;
  localparam int S_BELOW_RESTART = 12;

  typedef enum logic [2:0] {
    PSS_SEQ_OFF,
    PSS_SEQ_CORE,
    PSS_SEQ_DIGI,
    PSS_SEQ_ANA,
    PSS_SEQ_ON
  } pss_seq_t;

  typedef enum logic [2:0] {
    PSS_CHG_IDLE,
    PSS_CHG_PRE,
    PSS_CHG_CC,
    PSS_CHG_CV,
    PSS_CHG_MAINT
  } pss_chg_t;

endpackage : pss_pkg

// ==== src/pss_sync.sv ====
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module pss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // Two stages per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;

endmodule : pss_sync

// ==== src/pss_sequencer.sv ====
// Supply start-up sequencer, regulator enable gating and charger mode control
//
// How it works
// RQ1: Core regulator starts first; digital, then analog, follow once core regulates.
// RQ2: Core, digital and analog start at 1.8 V, 3.0 V, 3.0 V defaults.
// RQ3: Oscillator, receive, transmit regulators start after digital only if their pin high.
// RQ4: Serial enables for general, core, analog act only after power hold asserted.
// RQ5: Core and digital, when enabled, must regulate or the powered state ends.
// RQ6: Digital regulator has no enable control; always on while powered.
// RQ7: Charger has pre-charge, constant current, constant voltage, maintenance modes.
// RQ8: After a charge cycle, maintenance holds battery between termination and restart.
// RQ9: Full-rate charge current programmable 50 mA to 950 mA in 50 mA steps.
// RQ10: Constant-current setting resets to 100 mA.
// RQ11: Pre-charge current fixed at 50 mA, not programmable.
// RQ12: Termination voltage choices 4.1, 4.2, 4.3, 4.4 V; 4.2 V after reset.
// RQ13: Restart offset 100, 150 or 200 mV below termination; 150 mV after reset.
// RQ14: End-of-charge current 0.1C, 0.15C, 0.2C, 0.25C; 0.1C after reset.
// RQ15: USB source charging limits current to 100 mA or 450 mA.
// RQ16: Each enable pin enables its regulator high, disables it low.
// RQ17: Power request input high starts sequence; undriven it reads low.
// RQ18: System reset output low during power-up, high 60 ms after core stable.
// RQ19: In maintenance, battery below termination minus restart offset starts new cycle.
// RQ20: Host asserts power hold before expecting serial enables to take effect.
`timescale 1ns/10ps
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int RESET_DELAY = RESET_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Power control pins
  input wire logic power_request_input,
  input wire logic handsfree_power_request,
  input wire logic power_hold_input,
  input wire logic osc_supply_enable,
  input wire logic receive_supply_enable,
  input wire logic transmit_supply_enable,
  // Regulation status from the regulators
  input wire logic core_in_reg,
  input wire logic digital_in_reg,
  // Charger comparators
  input wire logic charge_source_ok,
  input wire logic vbat_below_precharge,
  input wire logic vbat_at_term,
  input wire logic ichg_below_eoc,
  input wire logic vbat_below_restart,
  // Serial-interface regulator settings
  input wire logic ldo_cfg_wr,
  input wire logic cfg_core_en,
  input wire logic cfg_analog_en,
  input wire logic cfg_general_en,
  input wire logic [3:0] cfg_core_vsel,
  input wire logic [3:0] cfg_digital_vsel,
  input wire logic [3:0] cfg_analog_vsel,
  // Serial-interface charger settings
  input wire logic chg_cfg_wr,
  input wire logic cfg_charger_en,
  input wire logic cfg_usb_source,
  input wire logic cfg_usb_high,
  input wire logic [4:0] cfg_ichg,
  input wire logic [1:0] cfg_term,
  input wire logic [1:0] cfg_restart,
  input wire logic [1:0] cfg_eoc,
  // Regulator controls
  output logic core_regulator_en,
  output logic digital_regulator_en,
  output logic analog_regulator_en,
  output logic oscillator_regulator_en,
  output logic receive_regulator_en,
  output logic transmit_regulator_en,
  output logic general_regulator_en,
  output logic [3:0] core_vsel,
  output logic [3:0] digital_vsel,
  output logic [3:0] analog_vsel,
  // System reset and status
  output logic sys_reset_n,
  output logic powered,
  // Charger controls
  output pss_chg_t charge_mode,
  output logic [4:0] charge_current,
  output logic [1:0] term_sel,
  output logic [1:0] restart_sel,
  output logic [1:0] eoc_sel
);

  logic [SYNC_W-1:0] s;

  // Every pin and analog status crosses two flops first
  pss_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({vbat_below_restart, ichg_below_eoc, vbat_at_term, vbat_below_precharge,
               charge_source_ok, digital_in_reg, core_in_reg, transmit_supply_enable,
               receive_supply_enable, osc_supply_enable, power_hold_input,
               handsfree_power_request, power_request_input}),
    .sync_out(s)
  );

  // ---------------- Settings held for the serial interface
  logic core_en_reg, core_en_next;
  logic ana_en_reg, ana_en_next;
  logic gp_en_reg, gp_en_next;
  logic [3:0] core_vsel_reg, core_vsel_next;
  logic [3:0] digi_vsel_reg, digi_vsel_next;
  logic [3:0] ana_vsel_reg, ana_vsel_next;
  logic chg_en_reg, chg_en_next;
  logic usb_reg, usb_next;
  logic usb_high_reg, usb_high_next;
  logic [4:0] ichg_reg, ichg_next;
  logic [1:0] term_reg, term_next;
  logic [1:0] restart_reg, restart_next;
  logic [1:0] eoc_reg, eoc_next;

  // Out-of-range codes are dropped so the setting never leaves its legal range
  always_comb begin
    core_en_next = core_en_reg;
    ana_en_next = ana_en_reg;
    gp_en_next = gp_en_reg;
    core_vsel_next = core_vsel_reg;
    digi_vsel_next = digi_vsel_reg;
    ana_vsel_next = ana_vsel_reg;
    chg_en_next = chg_en_reg;
    usb_next = usb_reg;
    usb_high_next = usb_high_reg;
    ichg_next = ichg_reg;
    term_next = term_reg;
    restart_next = restart_reg;
    eoc_next = eoc_reg;
    if (ldo_cfg_wr) begin
      core_en_next = cfg_core_en;
      ana_en_next = cfg_analog_en;
      gp_en_next = cfg_general_en;
      core_vsel_next = cfg_core_vsel;
      digi_vsel_next = cfg_digital_vsel;
      ana_vsel_next = cfg_analog_vsel;
    end
    if (chg_cfg_wr) begin
      chg_en_next = cfg_charger_en;
      usb_next = cfg_usb_source;
      usb_high_next = cfg_usb_high;
      if (cfg_ichg >= ICHG_MIN_CODE && cfg_ichg <= ICHG_MAX_CODE) begin
        ichg_next = cfg_ichg; // RQ9
      end
      term_next = cfg_term; // RQ12
      if (cfg_restart != RESTART_RESERVED) begin
        restart_next = cfg_restart; // RQ13
      end
      eoc_next = cfg_eoc; // RQ14
    end
  end

  // Settings registers with their documented defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_en_reg <= 1'b1;
      ana_en_reg <= 1'b1;
      gp_en_reg <= 1'b0;
      core_vsel_reg <= CORE_VSEL_RESET;
      digi_vsel_reg <= DIGI_VSEL_RESET;
      ana_vsel_reg <= ANA_VSEL_RESET;
      chg_en_reg <= 1'b1;
      usb_reg <= 1'b0;
      usb_high_reg <= 1'b0;
      ichg_reg <= ICHG_RESET; // RQ10
      term_reg <= TERM_RESET; // RQ12
      restart_reg <= RESTART_RESET; // RQ13
      eoc_reg <= EOC_RESET; // RQ14
    end else begin
      core_en_reg <= core_en_next;
      ana_en_reg <= ana_en_next;
      gp_en_reg <= gp_en_next;
      core_vsel_reg <= core_vsel_next;
      digi_vsel_reg <= digi_vsel_next;
      ana_vsel_reg <= ana_vsel_next;
      chg_en_reg <= chg_en_next;
      usb_reg <= usb_next;
      usb_high_reg <= usb_high_next;
      ichg_reg <= ichg_next;
      term_reg <= term_next;
      restart_reg <= restart_next;
      eoc_reg <= eoc_next;
    end
  end

  // ---------------- Start-up sequencer
  pss_seq_t seq_reg, seq_next;
  logic hold_reg, hold_next;
  logic [RESET_CNT_W-1:0] rcnt_reg, rcnt_next;
  logic rst_out_reg, rst_out_next;
  logic request;
  logic core_gated;
  logic core_fail;

  assign request = s[S_PWR_REQ] | s[S_HF_REQ]; // RQ17
  // Before hold the core stays on regardless of its serial setting
  assign core_gated = hold_reg ? core_en_reg : 1'b1; // RQ4
  // A core disabled by software no longer has to regulate
  assign core_fail = (core_gated && !s[S_CORE_OK]) || !s[S_DIGI_OK]; // RQ5

  always_comb begin
    seq_next = seq_reg;
    hold_next = hold_reg;
    rcnt_next = rcnt_reg;
    rst_out_next = rst_out_reg;
    unique case (seq_reg)
      PSS_SEQ_OFF: begin
        hold_next = 1'b0;
        if (request) begin
          seq_next = PSS_SEQ_CORE; // RQ17
        end
      end
      PSS_SEQ_CORE: begin
        if (s[S_CORE_OK]) begin
          seq_next = PSS_SEQ_DIGI; // RQ1
        end
      end
      PSS_SEQ_DIGI: begin
        if (!s[S_CORE_OK]) begin
          seq_next = PSS_SEQ_OFF; // RQ5
        end else if (s[S_DIGI_OK]) begin
          seq_next = PSS_SEQ_ANA; // RQ1
        end
      end
      PSS_SEQ_ANA: begin
        if (core_fail) begin
          seq_next = PSS_SEQ_OFF; // RQ5
        end else begin
          seq_next = PSS_SEQ_ON; // RQ1
        end
      end
      PSS_SEQ_ON: begin
        if (s[S_HOLD]) begin
          hold_next = 1'b1; // RQ4
        end
        // Powered state is kept by the request pins or by the synchronised power hold pin held high
        if (core_fail || (!request && !s[S_HOLD])) begin
          seq_next = PSS_SEQ_OFF; // RQ5
        end
      end
    endcase
    // Reset release counts from core reaching regulation
    if (seq_next == PSS_SEQ_OFF || seq_reg == PSS_SEQ_CORE) begin
      rcnt_next = '0;
      rst_out_next = 1'b0; // RQ18
    end else if (rcnt_reg == RESET_CNT_W'(RESET_DELAY - 1)) begin
      rst_out_next = 1'b1; // RQ18
    end else begin
      rcnt_next = rcnt_reg + RESET_CNT_W'(1); // RQ18
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= PSS_SEQ_OFF;
      hold_reg <= 1'b0;
      rcnt_reg <= '0;
      rst_out_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      hold_reg <= hold_next;
      rcnt_reg <= rcnt_next;
      rst_out_reg <= rst_out_next;
    end
  end

  // Regulator enables decoded from sequencer state
  logic past_digi;
  assign past_digi = (seq_reg == PSS_SEQ_ANA) || (seq_reg == PSS_SEQ_ON);
  assign core_regulator_en = (seq_reg != PSS_SEQ_OFF) && core_gated; // RQ1
  assign digital_regulator_en = (seq_reg != PSS_SEQ_OFF) && (seq_reg != PSS_SEQ_CORE); // RQ6
  assign analog_regulator_en = past_digi && (hold_reg ? ana_en_reg : 1'b1); // RQ1 RQ4
  assign oscillator_regulator_en = past_digi && s[S_OSC_EN]; // RQ3 RQ16
  assign receive_regulator_en = past_digi && s[S_RX_EN]; // RQ3 RQ16
  assign transmit_regulator_en = past_digi && s[S_TX_EN]; // RQ3 RQ16
  assign general_regulator_en = past_digi && hold_reg && gp_en_reg; // RQ4
  // Start-up always uses defaults; programmed levels apply once hold is seen
  assign core_vsel = hold_reg ? core_vsel_reg : CORE_VSEL_RESET; // RQ2
  assign digital_vsel = hold_reg ? digi_vsel_reg : DIGI_VSEL_RESET; // RQ2
  assign analog_vsel = hold_reg ? ana_vsel_reg : ANA_VSEL_RESET; // RQ2
  assign sys_reset_n = rst_out_reg;
  assign powered = (seq_reg == PSS_SEQ_ON);

  // ---------------- Charger mode control
  pss_chg_t chg_reg, chg_next;
  logic [4:0] icur_reg, icur_next;
  logic [4:0] usb_lim;
  logic [4:0] cc_cur;

  assign usb_lim = usb_high_reg ? ICHG_USB_HIGH : ICHG_USB_LOW; // RQ15
  assign cc_cur = (usb_reg && ichg_reg > usb_lim) ? usb_lim : ichg_reg; // RQ15

  // Mode walk; loss of source or enable drops straight to idle
  always_comb begin
    chg_next = chg_reg;
    if (!chg_en_reg || !s[S_SRC_OK]) begin
      chg_next = PSS_CHG_IDLE;
    end else begin
      unique case (chg_reg)
        PSS_CHG_IDLE: begin
          chg_next = s[S_BELOW_PRE] ? PSS_CHG_PRE : PSS_CHG_CC; // RQ7
        end
        PSS_CHG_PRE: begin
          if (!s[S_BELOW_PRE]) begin
            chg_next = PSS_CHG_CC; // RQ7
          end
        end
        PSS_CHG_CC: begin
          if (s[S_AT_TERM]) begin
            chg_next = PSS_CHG_CV; // RQ7
          end
        end
        PSS_CHG_CV: begin
          if (s[S_BELOW_EOC]) begin
            chg_next = PSS_CHG_MAINT; // RQ8
          end
        end
        PSS_CHG_MAINT: begin
          if (s[S_BELOW_RESTART]) begin
            chg_next = PSS_CHG_IDLE; // RQ19
          end
        end
      endcase
    end
    unique case (chg_next)
      PSS_CHG_PRE: icur_next = ICHG_PRECHARGE; // RQ11
      PSS_CHG_CC, PSS_CHG_CV: icur_next = cc_cur; // RQ9
      default: icur_next = 5'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chg_reg <= PSS_CHG_IDLE;
      icur_reg <= 5'h00;
    end else begin
      chg_reg <= chg_next;
      icur_reg <= icur_next;
    end
  end

  assign charge_mode = chg_reg;
  assign charge_current = icur_reg;
  assign term_sel = term_reg; // RQ8
  assign restart_sel = restart_reg; // RQ8
  assign eoc_sel = eoc_reg;

endmodule : pss_sequencer

// ==== verification/pss_sequencer_asserts.sv ====
// Concurrent checks on the supply sequencer ports
`timescale 1ns/10ps
module pss_sequencer_asserts
  import pss_pkg::*;
#(
  parameter int RESET_DELAY = RESET_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins and regulation
  input wire logic power_request_input,
  input wire logic handsfree_power_request,
  input wire logic osc_supply_enable,
  input wire logic digital_in_reg,
  // Regulator controls and status
  input wire logic core_regulator_en,
  input wire logic digital_regulator_en,
  input wire logic analog_regulator_en,
  input wire logic oscillator_regulator_en,
  input wire logic [3:0] core_vsel,
  input wire logic [3:0] digital_vsel,
  input wire logic [3:0] analog_vsel,
  input wire logic sys_reset_n,
  input wire logic powered,
  // Charger
  input wire pss_chg_t charge_mode,
  input wire logic [4:0] charge_current,
  input wire logic [1:0] restart_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Counts the wait for system reset release; a plain delay could not take the parameter
  int wait_reg, wait_next;
  always_comb begin
    wait_next = 0;
    if (digital_regulator_en)
      wait_next = sys_reset_n ? wait_reg : wait_reg + 1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      wait_reg <= 0;
    else
      wait_reg <= wait_next;
  end
  // Two sync flops plus one state update
  sequence s_core_up; ##3 core_regulator_en; endsequence
  sequence s_off_after; ##3 !powered; endsequence
  req_starts_core_a: assert property ($rose(power_request_input) && !handsfree_power_request
    && !core_regulator_en && !digital_regulator_en |-> s_core_up) else $error("no core start");
  core_first_a: assert property ($rose(digital_regulator_en) |-> core_regulator_en
    && !analog_regulator_en) else $error("digital started out of order");
  ana_after_digi_a: assert property ($rose(analog_regulator_en) |-> digital_regulator_en)
    else $error("analog started before digital");
  start_volts_a: assert property ($rose(core_regulator_en) && !powered |->
    core_vsel == VSEL_1V8 && digital_vsel == VSEL_3V0 && analog_vsel == VSEL_3V0)
    else $error("start voltages not default");
  osc_follows_pin_a: assert property (oscillator_regulator_en |-> digital_regulator_en
    && $past(osc_supply_enable, 2)) else $error("oscillator enable wrong");
  digi_always_on_a: assert property (powered |-> digital_regulator_en)
    else $error("digital off while powered");
  reg_loss_off_a: assert property (powered && !digital_in_reg |-> s_off_after)
    else $error("powered kept after regulation loss");
  reset_delay_a: assert property ($rose(sys_reset_n) |->
    wait_reg inside {[RESET_DELAY - 1:RESET_DELAY + 1]}) else $error("reset release delay");
  reset_on_off_a: assert property ($fell(powered) |-> ##[0:1] !sys_reset_n)
    else $error("system reset high when off");
  mode_order_a: assert property ($changed(charge_mode) && charge_mode inside {PSS_CHG_CV,
    PSS_CHG_MAINT} |-> $past(charge_mode) + 1 == charge_mode) else $error("mode order");
  pre_fixed_a: assert property (charge_mode == PSS_CHG_PRE |->
    charge_current == ICHG_PRECHARGE) else $error("pre-charge current");
  cc_range_a: assert property (charge_mode == PSS_CHG_CC |->
    charge_current inside {[ICHG_MIN_CODE:ICHG_MAX_CODE]}) else $error("charge current range");
  restart_legal_a: assert property (restart_sel != RESTART_RESERVED)
    else $error("reserved restart offset");
endmodule : pss_sequencer_asserts

bind pss_sequencer pss_sequencer_asserts #(.RESET_DELAY(RESET_DELAY)) chk_u (.*);

// ==== verification/pss_board_model.sv ====
// Regulator settling model standing behind the sequencer enables
`timescale 1ns/10ps
module pss_board_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Enables, drop_digi forces a regulation fault
  input wire logic core_en,
  input wire logic digi_en,
  input wire logic drop_digi,
  // Regulation flags
  output logic core_ok,
  output logic digi_ok
);
  int core_cnt_reg, digi_cnt_reg;
  // Regulation comes LAT cycles after enable and is lost at once on disable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_cnt_reg <= 0;
      digi_cnt_reg <= 0;
    end else begin
      core_cnt_reg <= core_en ? (core_cnt_reg < LAT ? core_cnt_reg + 1 : LAT) : 0;
      digi_cnt_reg <= digi_en && !drop_digi ? (digi_cnt_reg < LAT ? digi_cnt_reg + 1 : LAT) : 0;
    end
  end
  assign core_ok = core_cnt_reg == LAT;
  assign digi_ok = digi_cnt_reg == LAT;
endmodule : pss_board_model

// ==== verification/test_pmu_supply_sequencer.sv ====
// Self-checking bench for the supply sequencer
`timescale 1ns/10ps
module test_pmu_supply_sequencer;
  import pss_pkg::*;
  typedef struct {int s; logic [7:0] e;} pss_note_t;
  logic clk, reset_n, power_request_input, handsfree_power_request, power_hold_input;
  logic osc_supply_enable, receive_supply_enable, transmit_supply_enable, core_in_reg;
  logic digital_in_reg, charge_source_ok, vbat_below_precharge, vbat_at_term, ichg_below_eoc;
  logic vbat_below_restart, ldo_cfg_wr, cfg_core_en, cfg_analog_en, cfg_general_en, chg_cfg_wr;
  logic cfg_charger_en, cfg_usb_source, cfg_usb_high, drop_digi, sys_reset_n, powered;
  logic [3:0] cfg_core_vsel, cfg_digital_vsel, cfg_analog_vsel, core_vsel, digital_vsel, analog_vsel;
  logic [4:0] cfg_ichg, charge_current, ich, lim;
  logic [1:0] cfg_term, cfg_restart, cfg_eoc, term_sel, restart_sel, eoc_sel;
  logic core_regulator_en, digital_regulator_en, analog_regulator_en, oscillator_regulator_en;
  logic receive_regulator_en, transmit_regulator_en, general_regulator_en;
  pss_chg_t charge_mode;
  logic [16:0] rnd = 17'h16C2B;
  logic [7:0] ob [17];
  pss_note_t notes[$];
  pss_note_t n;
  // Printable names of the watched outputs, same order as ob
  string nm [17] = '{"core_en", "digital_en", "analog_en", "osc_en", "rx_en", "tx_en",
    "general_en", "sys_reset_n", "powered", "charge_mode", "charge_current", "term_sel",
    "restart_sel", "eoc_sel", "core_vsel", "digital_vsel", "analog_vsel"};
  int failures = 0, total_checks = 0, k;

  pss_sequencer #(.RESET_DELAY(20)) dut_u (.*);
  pss_board_model brd_u (.clk(clk), .reset_n(reset_n), .core_en(core_regulator_en),
    .digi_en(digital_regulator_en), .drop_digi(drop_digi), .core_ok(core_in_reg),
    .digi_ok(digital_in_reg));

  always #5 clk = ~clk;
  // Output index: 0 core 1 digi 2 ana 3 osc 4 rx 5 tx 6 gen 7 sysrst 8 powered 9 mode
  // 10 current 11 term 12 restart 13 eoc 14-16 vsel core, digital, analog
  always_comb ob = '{core_regulator_en, digital_regulator_en, analog_regulator_en,
    oscillator_regulator_en, receive_regulator_en, transmit_regulator_en, general_regulator_en,
    sys_reset_n, powered, charge_mode, charge_current, term_sel, restart_sel, eoc_sel,
    core_vsel, digital_vsel, analog_vsel};

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input int s, input logic [7:0] e);
    notes.push_back('{s, e});
  endtask : chk
  task automatic compare(input int s, input logic [7:0] seen, input logic [7:0] e);
    total_checks++;
    if (seen !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm[s], e, seen);
    end
  endtask : compare
  task automatic tally_and_finish;
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_v(input int s, input logic [7:0] v);
    for (int i = 0; i < 200 && ob[s] !== v; i++)
      step(1);
    if (ob[s] !== v) begin
      failures++;
      tally_and_finish();
    end
  endtask : wait_v
  task automatic chg_wr;
    chg_cfg_wr = 1'h1;
    step(1);
    chg_cfg_wr = 1'h0;
    step(2);
  endtask : chg_wr

  // Notes are compared mid-cycle, once the outputs have settled
  always @(negedge clk)
    while (notes.size() > 0) begin
      n = notes.pop_front();
      compare(n.s, ob[n.s], n.e);
    end

  initial begin
    {clk, reset_n, power_request_input, handsfree_power_request, power_hold_input,
      osc_supply_enable, receive_supply_enable, transmit_supply_enable, charge_source_ok,
      vbat_below_precharge, vbat_at_term, ichg_below_eoc, vbat_below_restart, ldo_cfg_wr,
      cfg_core_en, cfg_analog_en, cfg_general_en, cfg_core_vsel, cfg_digital_vsel,
      cfg_analog_vsel, chg_cfg_wr, cfg_usb_source, cfg_usb_high, cfg_ichg, cfg_term,
      cfg_restart, cfg_eoc, drop_digi} = '0;
    cfg_charger_en = 1'h1;
    step(2);
    reset_n = 1'h1;
    chk(11, 8'h01);
    chk(12, 8'h01);
    chk(13, 8'h00);
    // Start-up with random side pins
    rnd = lfsr(rnd);
    {receive_supply_enable, transmit_supply_enable} = rnd[1:0];
    osc_supply_enable = 1'h1;
    power_request_input = 1'h1;
    wait_v(0, 8'h01);
    chk(1, 8'h00);
    chk(14, VSEL_1V8);
    wait_v(1, 8'h01);
    chk(2, 8'h00);
    wait_v(2, 8'h01);
    chk(3, 8'h01);
    chk(4, receive_supply_enable);
    chk(5, transmit_supply_enable);
    wait_v(8, 8'h01);
    chk(7, 8'h00);
    wait_v(7, 8'h01);
    // Serial enables are ignored until power hold
    {cfg_core_en, cfg_general_en, cfg_core_vsel, cfg_analog_vsel} = {2'h3, 4'h5, 4'h7};
    ldo_cfg_wr = 1'h1;
    step(1);
    ldo_cfg_wr = 1'h0;
    step(4);
    chk(2, 8'h01);
    chk(6, 8'h00);
    chk(14, VSEL_1V8);
    power_hold_input = 1'h1;
    step(4);
    chk(2, 8'h00);
    chk(6, 8'h01);
    chk(14, 8'h05);
    osc_supply_enable = 1'h0;
    step(3);
    chk(3, 8'h00);
    // Regulation loss while held
    power_request_input = 1'h0;
    drop_digi = 1'h1;
    wait_v(8, 8'h00);
    chk(0, 8'h00);
    chk(7, 8'h00);
    {power_hold_input, drop_digi} = 2'h0;
    step(2);
    handsfree_power_request = 1'h1;
    wait_v(0, 8'h01);
    chk(14, VSEL_1V8);
    chk(15, VSEL_3V0);
    chk(16, VSEL_3V0);
    wait_v(8, 8'h01);
    // Charger walk
    {charge_source_ok, vbat_below_precharge} = 2'h3;
    wait_v(9, PSS_CHG_PRE);
    chk(10, ICHG_PRECHARGE);
    vbat_below_precharge = 1'h0;
    wait_v(9, PSS_CHG_CC);
    chk(10, ICHG_RESET);
    rnd = lfsr(rnd);
    ich = 5'(rnd % 19 + 1);
    cfg_ichg = ich;
    chg_cfg_wr = 1'h1;
    for (k = 0; k < 4; k++) begin
      {cfg_term, cfg_restart, cfg_eoc} = {2'(k), 2'(k), 2'(3 - k)};
      step(1);
      chk(11, 8'(k));
      chk(12, k == 3 ? 8'h02 : 8'(k));
      chk(13, 8'(3 - k));
    end
    chg_cfg_wr = 1'h0;
    step(2);
    chk(10, ich);
    cfg_usb_source = 1'h1;
    for (k = 0; k < 2; k++) begin
      cfg_usb_high = k[0];
      lim = k ? ICHG_USB_HIGH : ICHG_USB_LOW;
      chg_wr();
      chk(10, ich < lim ? ich : lim);
    end
    vbat_at_term = 1'h1;
    wait_v(9, PSS_CHG_CV);
    ichg_below_eoc = 1'h1;
    wait_v(9, PSS_CHG_MAINT);
    chk(10, 8'h00);
    {vbat_at_term, ichg_below_eoc, vbat_below_restart} = 3'h1;
    wait_v(9, PSS_CHG_IDLE);
    vbat_below_restart = 1'h0;
    wait_v(9, PSS_CHG_CC);
    // Charger disable drops to idle; code 0 is refused so the current survives
    cfg_charger_en = 1'h0;
    cfg_ichg = 5'h00;
    chg_wr();
    chk(9, PSS_CHG_IDLE);
    chk(10, 8'h00);
    cfg_charger_en = 1'h1;
    chg_wr();
    chk(9, PSS_CHG_CC);
    chk(10, ich < ICHG_USB_HIGH ? ich : ICHG_USB_HIGH);
    step(2);
    tally_and_finish();
  end
endmodule : test_pmu_supply_sequencer
